// File: hdl/wdb_pkg.sv
// Watchdog timer block: shared constants for register map and fields.
// Assumes a 32-bit APB slave port and a single always-on clock.
package wdb_pkg;
    localparam int          WDB_CNT_W        = 32;
    localparam int          WDB_SEL_W        = 4;
    localparam int          WDB_EXP_BASE     = 16;
    localparam logic [7:0]  WDB_RESTART_KEY  = 8'h76;
    localparam logic [11:0] WDB_OFS_CTRL     = 12'h000;
    localparam logic [11:0] WDB_OFS_RANGE    = 12'h004;
    localparam logic [11:0] WDB_OFS_COUNT    = 12'h008;
    localparam logic [11:0] WDB_OFS_RESTART  = 12'h00c;
    localparam logic [11:0] WDB_OFS_STATUS   = 12'h010;
    localparam logic [11:0] WDB_OFS_INTCLR   = 12'h014;
    localparam int          WDB_CTRL_EN_BIT  = 0;
    localparam int          WDB_CTRL_MOD_BIT = 1;
    localparam int          WDB_RANGE_RST_LO = 0;
    localparam int          WDB_RANGE_INI_LO = 4;
    localparam logic [3:0]  WDB_SEL_RESET    = 4'h0;
    localparam logic [31:0] WDB_CNT_RESET    = 32'h0000_0000;
endpackage

// File: hdl/wdb_watchdog.sv
// Watchdog timer block: APB slave, down counter and timeout responses.
// Assumes pclk is the always-on free clock; pause comes from system manager.
`timescale 1ns/100ps

module wdb_watchdog
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        wdog_pause,
    output logic             wdog_irq,
    output logic             wdog_rst_req
);
    import wdb_pkg::*;

    typedef enum logic [1:0]
    {
        WDB_IDLE  = 2'b00,
        WDB_FIRST = 2'b01,
        WDB_SECND = 2'b10
    } wdb_state_t;

    wdb_state_t             state;
    wdb_state_t             next_state;
    logic [WDB_CNT_W-1:0]   count;
    logic [WDB_CNT_W-1:0]   next_count;
    logic                   enable;
    logic                   mode_irq;
    logic [WDB_SEL_W-1:0]   sel_init;
    logic [WDB_SEL_W-1:0]   sel_rest;
    logic                   irq;
    logic                   rst_req;
    logic                   next_irq;

    wire access   = psel && penable;
    wire wr       = access && pwrite;
    wire rd       = access && !pwrite;
    wire hit_ctrl = paddr == WDB_OFS_CTRL;
    wire hit_rng  = paddr == WDB_OFS_RANGE;
    wire hit_cnt  = paddr == WDB_OFS_COUNT;
    wire hit_rst  = paddr == WDB_OFS_RESTART;
    wire hit_sts  = paddr == WDB_OFS_STATUS;
    wire hit_clr  = paddr == WDB_OFS_INTCLR;
    wire mapped   = hit_ctrl || hit_rng || hit_cnt || hit_rst
                    || hit_sts || hit_clr;

    wire wr_ctrl  = wr && hit_ctrl && pstrb[0];
    wire wr_rng   = wr && hit_rng && pstrb[0];
    // Key checked on the low byte only
    wire restart_wr = wr && hit_rst && pstrb[0]
                      && (pwdata[7:0] == WDB_RESTART_KEY);
    wire clr_rd     = rd && hit_clr;
    wire restart    = enable && (restart_wr || clr_rd);
    wire start      = !enable && wr_ctrl && pwdata[WDB_CTRL_EN_BIT];
    wire at_zero    = enable && (count == '0);
    wire timeout    = at_zero && !restart && !wdog_pause;

    // Period minus one: 2^(16+i) - 1 clock cycles
    wire [WDB_CNT_W-1:0] load_init =
        WDB_CNT_W'((33'd1 << (WDB_EXP_BASE + 32'(sel_init))) - 33'd1);
    wire [WDB_CNT_W-1:0] load_rest =
        WDB_CNT_W'((33'd1 << (WDB_EXP_BASE + 32'(sel_rest))) - 33'd1);

    always_comb
    begin
        next_count = count;
        next_state = state;
        next_irq   = irq;
        if (start)
        begin
            next_count = load_init;
            next_state = WDB_FIRST;
        end
        else if (restart)
        begin
            next_count = load_rest;
            next_state = WDB_FIRST;
            next_irq   = 1'b0;
        end
        else if (timeout)
        begin
            next_count = load_rest;
            case (state)
                WDB_FIRST:
                begin
                    if (mode_irq)
                    begin
                        next_irq   = 1'b1;
                        next_state = WDB_SECND;
                    end
                end
                default:
                begin
                    next_state = state;
                end
            endcase
        end
        else if (enable && !wdog_pause)
        begin
            next_count = WDB_CNT_W'(count - 32'd1);
        end
    end

    // Reset request when not answered by interrupt path
    wire req_rst = timeout && (!mode_irq || state == WDB_SECND);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state   <= WDB_IDLE;
            count   <= WDB_CNT_RESET;
            enable  <= 1'b0;
            irq     <= 1'b0;
            rst_req <= 1'b0;
        end
        else
        begin
            state   <= next_state;
            count   <= next_count;
            irq     <= next_irq;
            if (start)
            begin
                enable <= 1'b1;
            end
            if (req_rst)
            begin
                rst_req <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_irq <= 1'b0;
            sel_init <= WDB_SEL_RESET;
            sel_rest <= WDB_SEL_RESET;
        end
        else
        begin
            if (wr_ctrl)
            begin
                mode_irq <= pwdata[WDB_CTRL_MOD_BIT];
            end
            if (wr_rng)
            begin
                sel_rest <= pwdata[WDB_RANGE_RST_LO +: 4];
                sel_init <= pwdata[WDB_RANGE_INI_LO +: 4];
            end
        end
    end

    wire [31:0] rd_ctrl = {30'h0, mode_irq, enable};
    wire [31:0] rd_rng  = {24'h0, sel_init, sel_rest};
    wire [31:0] rd_sts  = {30'h0, rst_req, irq};
    wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl :
                          hit_rng  ? rd_rng  :
                          hit_cnt  ? count   :
                          hit_sts  ? rd_sts  : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (psel && !penable && !pwrite)
        begin
            prdata <= rd_mux;
        end
    end

    assign pready       = 1'b1;
    assign pslverr      = access && !mapped;
    assign wdog_irq     = irq;
    assign wdog_rst_req = rst_req;

    chk_restart_reload: assert property (
        @(posedge pclk) disable iff (!presetn)
        restart |=> (count == $past(load_rest)) && !irq)
        else $error("restart did not reload counter");

    chk_zero_restart: assert property (
        @(posedge pclk) disable iff (!presetn)
        (at_zero && restart && !irq && !rst_req)
        |=> !irq && !rst_req)
        else $error("timeout response despite restart");

    chk_decrement_one: assert property (
        @(posedge pclk) disable iff (!presetn)
        (enable && !wdog_pause && !restart && count != '0)
        |=> count == $past(count) - 32'd1)
        else $error("counter did not decrement by one");

    chk_pause_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wdog_pause && !restart && !start)
        |=> $stable(count))
        else $error("counter moved while paused");

    chk_enable_sticky: assert property (
        @(posedge pclk) disable iff (!presetn)
        enable |=> enable)
        else $error("enable dropped without reset");

    chk_reset_mode: assert property (
        @(posedge pclk) disable iff (!presetn)
        (timeout && !mode_irq) |=> wdog_rst_req)
        else $error("no reset request in reset mode");

    chk_first_irq: assert property (
        @(posedge pclk) disable iff (!presetn)
        (timeout && mode_irq && state == WDB_FIRST)
        |=> wdog_irq && !wdog_rst_req && count == $past(load_rest))
        else $error("first timeout not handled as interrupt");

    chk_start_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        start |=> enable && count == $past(load_init))
        else $error("enable did not load initial period");

    chk_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        (irq && !restart) |=> irq)
        else $error("interrupt dropped without clear");

    chk_zero_reload: assert property (
        @(posedge pclk) disable iff (!presetn)
        timeout |=> count == $past(load_rest))
        else $error("counter not reloaded after timeout");

    chk_disabled_quiet: assert property (
        @(posedge pclk) disable iff (!presetn)
        !enable |-> !wdog_irq && !wdog_rst_req && state == WDB_IDLE)
        else $error("outputs active while disabled");

    chk_idle_frozen: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!enable && !start) |=> !enable && $stable(count))
        else $error("disabled counter moved");

    chk_key_guard: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr && hit_rst && pwdata[7:0] != WDB_RESTART_KEY)
        |-> !restart)
        else $error("restart taken without key");

    chk_key_reload: assert property (
        @(posedge pclk) disable iff (!presetn)
        (enable && wr && hit_rst && pstrb[0]
         && pwdata[7:0] == WDB_RESTART_KEY)
        |=> count == $past(load_rest))
        else $error("keyed restart did not reload");

    chk_clr_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        (enable && rd && hit_clr) |=> !wdog_irq
        && count == $past(load_rest))
        else $error("interrupt clear read had no effect");

    chk_second_reset: assert property (
        @(posedge pclk) disable iff (!presetn)
        (timeout && mode_irq && state == WDB_SECND) |=> wdog_rst_req)
        else $error("second timeout did not request reset");

    chk_rst_sticky: assert property (
        @(posedge pclk) disable iff (!presetn)
        wdog_rst_req |=> wdog_rst_req)
        else $error("reset request dropped without reset");

    chk_init_period: assert property (
        @(posedge pclk) disable iff (!presetn)
        start |=> $onehot(count + 32'h0000_0001)
        && count >= 32'h0000_ffff)
        else $error("initial period not a power of two");

    chk_rest_period: assert property (
        @(posedge pclk) disable iff (!presetn)
        restart |=> $onehot(count + 32'h0000_0001)
        && count >= 32'h0000_ffff)
        else $error("restart period not a power of two");

    chk_range_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_rng |=> sel_init == $past(pwdata[WDB_RANGE_INI_LO +: 4])
        && sel_rest == $past(pwdata[WDB_RANGE_RST_LO +: 4]))
        else $error("timeout selectors not stored apart");

    chk_mode_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_ctrl |=> mode_irq == $past(pwdata[WDB_CTRL_MOD_BIT]))
        else $error("mode bit not stored");

    chk_irq_cause: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(wdog_irq) |-> $past(timeout) && $past(mode_irq))
        else $error("interrupt raised without timeout");

    chk_irq_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        $fell(wdog_irq) |-> $past(restart))
        else $error("interrupt cleared without service");

    chk_rst_cause: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(wdog_rst_req) |-> $past(timeout))
        else $error("reset request without timeout");

    chk_pause_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        (at_zero && wdog_pause && !restart)
        |=> count == '0 && $stable(wdog_irq))
        else $error("paused counter left zero");

    chk_enable_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_ctrl && !pwdata[WDB_CTRL_EN_BIT] && !enable) |=> !enable)
        else $error("enable set without writing one");

endmodule

// File: verification/wdb_pause_src.sv
// Pause source model standing in for the system manager.
// Assumes the debug flags are synchronous to pclk.
`timescale 1ns/100ps
module wdb_pause_src
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] cpu_dbg,
    input  wire logic [2:0] pause_sel_in,
    input  wire logic       sel_we,
    output logic            wdog_pause
);
    logic [2:0] pause_sel;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pause_sel <= 3'h0;
        else if (sel_we)
            pause_sel <= pause_sel_in;
    end
    // 0 any cpu, 1..4 one cpu, otherwise never
    assign wdog_pause = (pause_sel == 3'h0) ? |cpu_dbg :
                        (pause_sel <= 3'h4) ? cpu_dbg[pause_sel - 3'h1] :
                        1'b0;
endmodule

// File: verification/watchdog_timer_block_test.sv
// Self-checking bench for the watchdog: APB master and pause source.
// Assumes zero-wait APB slave and a 250 MHz clock.
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module watchdog_timer_block_test;
    import wdb_pkg::*;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d;
                    logic [31:0] r; logic e;} wdb_row_t;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hf;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        wdog_pause;
    logic        wdog_irq;
    logic        wdog_rst_req;
    logic [3:0]  cpu_dbg = 4'h0;
    logic [31:0] rd;
    logic        er;
    logic [31:0] held;
    logic [2:0]  pause_sel_in = 3'h0;
    logic        sel_we = 1'b0;
    int          bad_count = 0;
    int          check_count = 0;
    wdb_row_t    rows[7] = '{
        '{0, WDB_OFS_CTRL, 32'h0, 32'h0000_0000, 0},    // reset state
        '{0, WDB_OFS_STATUS, 32'h0, 32'h0000_0000, 0},
        '{0, WDB_OFS_COUNT, 32'h0, 32'h0000_0000, 0},
        '{1, WDB_OFS_RANGE, 32'h0000_0001, 32'h0, 0},
        '{0, WDB_OFS_RANGE, 32'h0, 32'h0000_0001, 0},
        '{0, 12'h018, 32'h0, 32'h0000_0000, 1},         // unmapped
        '{1, WDB_OFS_CTRL, 32'h0000_0002, 32'h0, 0}};
    always #2 pclk = ~pclk;
    wdb_watchdog DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wdog_pause(wdog_pause), .wdog_irq(wdog_irq),
        .wdog_rst_req(wdog_rst_req));
    wdb_pause_src sysmgr (.pclk(pclk), .presetn(presetn), .cpu_dbg(cpu_dbg),
        .pause_sel_in(pause_sel_in), .sel_we(sel_we),
        .wdog_pause(wdog_pause));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge pclk);
            if (pready)
                break;
        end
        if (i == 20)
        begin
            bad_count++;
            give_verdict();
        end
        else
        begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[k])
        begin
            apb(rows[k].w, rows[k].a, rows[k].d);
            `CHK(er, rows[k].e)
            if (!rows[k].w)
                `CHK(rd, rows[k].r)
        end
        cpu_dbg <= 4'h1;
        apb(1, WDB_OFS_CTRL, 32'h0000_0003);
        apb(0, WDB_OFS_COUNT, 32'h0);
        `CHK(rd, 32'h0000_FFFF)
        apb(1, WDB_OFS_CTRL, 32'h0000_0002);
        apb(0, WDB_OFS_CTRL, 32'h0);
        `CHK(rd, 32'h0000_0003)
        apb(1, WDB_OFS_RESTART, 32'h0000_0075);
        apb(0, WDB_OFS_COUNT, 32'h0);
        `CHK(rd, 32'h0000_FFFF)
        apb(1, WDB_OFS_RESTART, 32'h0000_0076);
        apb(0, WDB_OFS_COUNT, 32'h0);
        `CHK(rd, 32'h0001_FFFF)
        apb(1, WDB_OFS_RANGE, 32'h0000_0000);
        apb(1, WDB_OFS_RESTART, 32'h0000_0076);
        apb(0, WDB_OFS_COUNT, 32'h0);
        `CHK(rd, 32'h0000_FFFF)
        cpu_dbg <= 4'h0;
        for (int i = 0; i < 70000 && wdog_irq !== 1'b1; i++)
            @(posedge pclk);
        `CHK(wdog_irq, 1'b1)
        `CHK(wdog_rst_req, 1'b0)
        if (wdog_irq !== 1'b1)
            give_verdict();
        apb(0, WDB_OFS_COUNT, 32'h0);
        `CHK(rd[31:16], 16'h0000)
        cpu_dbg <= 4'h8;
        apb(0, WDB_OFS_STATUS, 32'h0);
        `CHK(rd, 32'h0000_0001)
        apb(0, WDB_OFS_INTCLR, 32'h0);
        `CHK(wdog_irq, 1'b0)
        apb(0, WDB_OFS_COUNT, 32'h0);
        `CHK(rd, 32'h0000_FFFF)
        pause_sel_in <= 3'h2;
        sel_we <= 1'b1;
        @(posedge pclk);
        sel_we <= 1'b0;
        @(posedge pclk);
        apb(0, WDB_OFS_COUNT, 32'h0);
        `CHK(rd < 32'h0000_FFFF, 1'b1)
        cpu_dbg <= 4'h2;
        @(posedge pclk);
        apb(0, WDB_OFS_COUNT, 32'h0);
        held = rd;
        apb(0, WDB_OFS_COUNT, 32'h0);
        `CHK(rd, held)
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(0, WDB_OFS_CTRL, 32'h0);
        `CHK(rd, 32'h0000_0000)
        give_verdict();
    end
endmodule
